/* design/io_cfg_pkg.sv */
`default_nettype none

package io_cfg_pkg;

    // ----------------
    // Register offsets
    // ----------------
    localparam logic [5:0] OFS_IO_PIN_CONFIG_A = 6'h1C;
    localparam logic [5:0] OFS_IO_PIN_CONFIG_B = 6'h1D;
    localparam logic [5:0] OFS_MAKER_ID_LOW    = 6'h1E;
    localparam logic [5:0] OFS_MAKER_ID_HIGH   = 6'h1F;

    // ----------------
    // Field positions of io_pin_config_a
    // ----------------
    localparam int A_ACCEPT_BCN_BIT   = 11;
    localparam int A_LEVEL_INV_BIT    = 10;
    localparam int A_THRESH_INV_BIT   = 9;
    localparam int A_DELIM_INV_BIT    = 8;
    localparam int A_CLEAR_INV_BIT    = 7;
    localparam int A_THRESH_LSB       = 0;
    localparam int A_THRESH_W         = 7;

    // ----------------
    // Field positions of io_pin_config_b
    // ----------------
    localparam int B_DEBUG_SRC_LSB    = 10;
    localparam int B_DEBUG_SRC_W      = 3;
    localparam int B_DELIM_SEL_LSB    = 5;
    localparam int B_CLEAR_SEL_LSB    = 0;
    localparam int B_SEL_W            = 5;

    // ----------------
    // Field positions of the identity registers
    // ----------------
    localparam int ID_MAKER_LSB       = 1;
    localparam int ID_CONT_LSB        = 8;
    localparam int ID_PART_LO_LSB     = 12;
    localparam int ID_PART_HI_LSB     = 0;
    localparam int ID_REV_LSB         = 12;

    // ----------------
    // Reset values
    // ----------------
    localparam logic [6:0] RST_THRESH_LEVEL = 7'h40;
    localparam logic [2:0] RST_DEBUG_SRC    = 3'h0;
    localparam logic [4:0] RST_PIN_SELECT   = 5'h00;

    // ----------------
    // Debug serializer timing: prescaler ticks per data bit (150/37.5)
    // ----------------
    localparam int          PRE_CLK_MHZ_X10   = 1500;
    localparam int          DBG_CLK_MHZ_X10   = 375;
    localparam logic [1:0]  DBG_TICKS_PER_BIT = 2'((PRE_CLK_MHZ_X10 / DBG_CLK_MHZ_X10) - 1);
    localparam int          DBG_WORD_W        = 16;

    typedef enum logic [2:0]
    {
        DBG_OFF      = 3'h0,
        DBG_AGC      = 3'h1,
        DBG_ADC_OUT  = 3'h2,
        DBG_FILT_IQ  = 3'h3,
        DBG_RSVD4    = 3'h4,
        DBG_RSVD5    = 3'h5,
        DBG_ADC_IN   = 3'h6,
        DBG_DAC_IN   = 3'h7
    } debug_src_e;

    typedef struct packed
    {
        logic       accept_any_beacon;
        logic       rxbuf_level_pin_invert;
        logic       rxbuf_thresh_pin_invert;
        logic       frame_delim_pin_invert;
        logic       chan_clear_pin_invert;
        logic [6:0] rxbuf_thresh_level;
    } cfg_a_s;

    typedef struct packed
    {
        debug_src_e fast_debug_source;
        logic [4:0] frame_delim_pin_select;
        logic [4:0] chan_clear_pin_select;
    } cfg_b_s;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } reg_req_s;

endpackage

`default_nettype wire

/* design/debug_serializer.sv */
`timescale 1ns/1ps
`default_nettype none

module debug_serializer
(
    input  wire logic                                 clk_sys_i,
    input  wire logic                                 rst_n_i,
    input  wire logic                                 run_i,
    input  wire logic                                 pre_tick_i,
    input  wire logic [io_cfg_pkg::DBG_WORD_W-1:0]    word_i,
    output logic                                      word_take_o,
    output logic                                      dbg_clk_o,
    output logic                                      dbg_data_o
);

    typedef enum logic [0:0]
    {
        SER_IDLE  = 1'b0,
        SER_SHIFT = 1'b1
    } ser_state_e;

    ser_state_e                              state_q;
    logic [1:0]                              tick_q;
    logic [3:0]                              bit_q;
    logic [io_cfg_pkg::DBG_WORD_W-1:0]       shift_q;
    logic                                    bit_end;

    assign bit_end     = pre_tick_i && (tick_q == io_cfg_pkg::DBG_TICKS_PER_BIT);
    assign word_take_o = run_i && bit_end && (state_q == SER_IDLE || bit_q == 4'hF);

    // ----------------
    // Prescaler tick divider: one data bit every four ticks
    // ----------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || !run_i)
            tick_q <= 2'h0;
        else if (pre_tick_i)
            tick_q <= tick_q + 2'h1;
    end

    // ----------------
    // Shifter, MSB first, words back to back
    // ----------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || !run_i)
        begin
            state_q <= SER_IDLE;
            bit_q   <= 4'h0;
            shift_q <= '0;
        end
        else if (word_take_o)
        begin
            state_q <= SER_SHIFT;
            bit_q   <= 4'h0;
            shift_q <= word_i;
        end
        else if (bit_end)
        begin
            bit_q   <= bit_q + 4'h1;
            shift_q <= {shift_q[io_cfg_pkg::DBG_WORD_W-2:0], 1'b0};
        end
    end

    // Clock is high in the second half of each bit so data is stable at its rising edge
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            dbg_clk_o  <= 1'b0;
            dbg_data_o <= 1'b0;
        end
        else
        begin
            dbg_clk_o  <= (state_q == SER_SHIFT) && tick_q[1];
            dbg_data_o <= (state_q == SER_SHIFT) && shift_q[io_cfg_pkg::DBG_WORD_W-1];
        end
    end

endmodule

`default_nettype wire

/* design/io_config_and_id_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module io_config_and_id_regs
#(
    parameter logic [6:0]  MAKER_CODE   = 7'h15,  // arbitrary value
    parameter logic [3:0]  MAKER_CONT   = 4'h1,   // arbitrary value
    parameter logic [15:0] PART_NUMBER  = 16'h0A5C, // arbitrary value
    parameter logic [3:0]  REVISION     = 4'h1    // arbitrary value
)
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_n_i,
    // Register access from the serial interface
    input  wire io_cfg_pkg::reg_req_s  reg_req_i,
    output logic [15:0]                reg_rdata_o,
    output logic                       reg_rvalid_o,
    // Beacon filtering
    input  wire logic                  addr_filter_en_i,
    input  wire logic                  beacon_check_i,
    input  wire logic [15:0]           beacon_src_net_id_i,
    input  wire logic [15:0]           stored_net_id_i,
    output logic                       beacon_accept_o,
    output logic                       beacon_valid_o,
    // Status pins
    input  wire logic                  rxbuf_level_i,
    input  wire logic [7:0]            rxbuf_count_i,
    input  wire logic [31:0]           frame_delim_sources_i,
    input  wire logic [31:0]           chan_clear_sources_i,
    output logic                       rxbuf_level_pin_o,
    output logic                       rxbuf_thresh_pin_o,
    output logic                       frame_delim_pin_o,
    output logic                       chan_clear_pin_o,
    // Fast serial debug
    input  wire logic                  freq_synth_on_i,
    input  wire logic                  pre_tick_i,
    input  wire logic [15:0]           agc_status_i,
    input  wire logic [15:0]           adc_iq_out_i,
    input  wire logic [15:0]           filt_iq_i,
    input  wire logic [15:0]           adc_iq_in_i,
    input  wire logic [15:0]           dac_iq_in_i,
    output logic                       fast_serial_debug_clk_o,
    output logic                       fast_serial_debug_data_o,
    output logic                       fast_serial_debug_take_o
);

    io_cfg_pkg::cfg_a_s   cfg_a_q;
    io_cfg_pkg::cfg_b_s   cfg_b_q;
    logic [15:0]          cfg_a_word;
    logic [15:0]          cfg_b_word;
    logic [15:0]          id_low_word;
    logic [15:0]          id_high_word;
    logic [15:0]          rdata_d;
    logic                 thresh_hit;
    logic                 dbg_run;
    logic [15:0]          dbg_word;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Unused upper bits are not stored; the host keeps them zero anyway
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            cfg_a_q.accept_any_beacon       <= 1'b0;
            cfg_a_q.rxbuf_level_pin_invert  <= 1'b0;
            cfg_a_q.rxbuf_thresh_pin_invert <= 1'b0;
            cfg_a_q.frame_delim_pin_invert  <= 1'b0;
            cfg_a_q.chan_clear_pin_invert   <= 1'b0;
            cfg_a_q.rxbuf_thresh_level      <= io_cfg_pkg::RST_THRESH_LEVEL;
        end
        else if (reg_req_i.wr && reg_req_i.addr == io_cfg_pkg::OFS_IO_PIN_CONFIG_A)
        begin
            cfg_a_q.accept_any_beacon       <= reg_req_i.wdata[io_cfg_pkg::A_ACCEPT_BCN_BIT];
            cfg_a_q.rxbuf_level_pin_invert  <= reg_req_i.wdata[io_cfg_pkg::A_LEVEL_INV_BIT];
            cfg_a_q.rxbuf_thresh_pin_invert <= reg_req_i.wdata[io_cfg_pkg::A_THRESH_INV_BIT];
            cfg_a_q.frame_delim_pin_invert  <= reg_req_i.wdata[io_cfg_pkg::A_DELIM_INV_BIT];
            cfg_a_q.chan_clear_pin_invert   <= reg_req_i.wdata[io_cfg_pkg::A_CLEAR_INV_BIT];
            cfg_a_q.rxbuf_thresh_level      <=
                reg_req_i.wdata[io_cfg_pkg::A_THRESH_LSB +: io_cfg_pkg::A_THRESH_W];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            cfg_b_q.fast_debug_source      <= io_cfg_pkg::debug_src_e'(io_cfg_pkg::RST_DEBUG_SRC);
            cfg_b_q.frame_delim_pin_select <= io_cfg_pkg::RST_PIN_SELECT;
            cfg_b_q.chan_clear_pin_select  <= io_cfg_pkg::RST_PIN_SELECT;
        end
        else if (reg_req_i.wr && reg_req_i.addr == io_cfg_pkg::OFS_IO_PIN_CONFIG_B)
        begin
            cfg_b_q.fast_debug_source      <= io_cfg_pkg::debug_src_e'(
                reg_req_i.wdata[io_cfg_pkg::B_DEBUG_SRC_LSB +: io_cfg_pkg::B_DEBUG_SRC_W]);
            cfg_b_q.frame_delim_pin_select <=
                reg_req_i.wdata[io_cfg_pkg::B_DELIM_SEL_LSB +: io_cfg_pkg::B_SEL_W];
            cfg_b_q.chan_clear_pin_select  <=
                reg_req_i.wdata[io_cfg_pkg::B_CLEAR_SEL_LSB +: io_cfg_pkg::B_SEL_W];
        end
    end

    // ----------------------------------------------------------------
    // Read-back words
    // ----------------------------------------------------------------
    always_comb
    begin
        cfg_a_word = 16'h0000;
        cfg_a_word[io_cfg_pkg::A_ACCEPT_BCN_BIT] = cfg_a_q.accept_any_beacon;
        cfg_a_word[io_cfg_pkg::A_LEVEL_INV_BIT]  = cfg_a_q.rxbuf_level_pin_invert;
        cfg_a_word[io_cfg_pkg::A_THRESH_INV_BIT] = cfg_a_q.rxbuf_thresh_pin_invert;
        cfg_a_word[io_cfg_pkg::A_DELIM_INV_BIT]  = cfg_a_q.frame_delim_pin_invert;
        cfg_a_word[io_cfg_pkg::A_CLEAR_INV_BIT]  = cfg_a_q.chan_clear_pin_invert;
        cfg_a_word[io_cfg_pkg::A_THRESH_LSB +: io_cfg_pkg::A_THRESH_W] = cfg_a_q.rxbuf_thresh_level;
    end

    always_comb
    begin
        cfg_b_word = 16'h0000;
        cfg_b_word[io_cfg_pkg::B_DEBUG_SRC_LSB +: io_cfg_pkg::B_DEBUG_SRC_W] = cfg_b_q.fast_debug_source;
        cfg_b_word[io_cfg_pkg::B_DELIM_SEL_LSB +: io_cfg_pkg::B_SEL_W] = cfg_b_q.frame_delim_pin_select;
        cfg_b_word[io_cfg_pkg::B_CLEAR_SEL_LSB +: io_cfg_pkg::B_SEL_W] = cfg_b_q.chan_clear_pin_select;
    end

    always_comb
    begin
        id_low_word = 16'h0001;
        id_low_word[io_cfg_pkg::ID_MAKER_LSB +: 7]   = MAKER_CODE;
        id_low_word[io_cfg_pkg::ID_CONT_LSB +: 4]    = MAKER_CONT;
        id_low_word[io_cfg_pkg::ID_PART_LO_LSB +: 4] = PART_NUMBER[3:0];
    end

    always_comb
    begin
        id_high_word = 16'h0000;
        id_high_word[io_cfg_pkg::ID_PART_HI_LSB +: 12] = PART_NUMBER[15:4];
        id_high_word[io_cfg_pkg::ID_REV_LSB +: 4]      = REVISION;
    end

    // Identity registers ignore writes; unmapped offsets read zero
    always_comb
    begin
        unique case (reg_req_i.addr)
            io_cfg_pkg::OFS_IO_PIN_CONFIG_A: rdata_d = cfg_a_word;
            io_cfg_pkg::OFS_IO_PIN_CONFIG_B: rdata_d = cfg_b_word;
            io_cfg_pkg::OFS_MAKER_ID_LOW:    rdata_d = id_low_word;
            io_cfg_pkg::OFS_MAKER_ID_HIGH:   rdata_d = id_high_word;
            default:                         rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o  <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd)
                reg_rdata_o <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Beacon acceptance
    // ----------------------------------------------------------------
    // With filtering off, beacons are not screened here at all
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            beacon_accept_o <= 1'b0;
            beacon_valid_o  <= 1'b0;
        end
        else
        begin
            beacon_valid_o <= beacon_check_i;
            if (beacon_check_i)
                beacon_accept_o <= !addr_filter_en_i
                                || cfg_a_q.accept_any_beacon
                                || (beacon_src_net_id_i == stored_net_id_i);
        end
    end

    // ----------------------------------------------------------------
    // Status pins
    // ----------------------------------------------------------------
    assign thresh_hit = rxbuf_count_i >= {1'b0, cfg_a_q.rxbuf_thresh_level};

    // Inversion sits in the pin flop so the pads never glitch on a polarity change
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rxbuf_level_pin_o  <= 1'b0;
            rxbuf_thresh_pin_o <= 1'b0;
            frame_delim_pin_o  <= 1'b0;
            chan_clear_pin_o   <= 1'b0;
        end
        else
        begin
            rxbuf_level_pin_o  <= rxbuf_level_i ^ cfg_a_q.rxbuf_level_pin_invert;
            rxbuf_thresh_pin_o <= thresh_hit ^ cfg_a_q.rxbuf_thresh_pin_invert;
            frame_delim_pin_o  <= frame_delim_sources_i[cfg_b_q.frame_delim_pin_select]
                                ^ cfg_a_q.frame_delim_pin_invert;
            chan_clear_pin_o   <= chan_clear_sources_i[cfg_b_q.chan_clear_pin_select]
                                ^ cfg_a_q.chan_clear_pin_invert;
        end
    end

    // ----------------------------------------------------------------
    // Fast serial debug
    // ----------------------------------------------------------------
    always_comb
    begin
        dbg_run  = freq_synth_on_i;
        dbg_word = 16'h0000;
        unique case (cfg_b_q.fast_debug_source)
            io_cfg_pkg::DBG_AGC:     dbg_word = agc_status_i;
            io_cfg_pkg::DBG_ADC_OUT: dbg_word = adc_iq_out_i;
            io_cfg_pkg::DBG_FILT_IQ: dbg_word = filt_iq_i;
            io_cfg_pkg::DBG_ADC_IN:  dbg_word = adc_iq_in_i;
            io_cfg_pkg::DBG_DAC_IN:  dbg_word = dac_iq_in_i;
            default:                 dbg_run  = 1'b0;
        endcase
    end

    debug_serializer u_debug_serializer
    (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .run_i       (dbg_run),
        .pre_tick_i  (pre_tick_i),
        .word_i      (dbg_word),
        .word_take_o (fast_serial_debug_take_o),
        .dbg_clk_o   (fast_serial_debug_clk_o),
        .dbg_data_o  (fast_serial_debug_data_o)
    );

endmodule

`default_nettype wire

/* dv/io_cfg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module io_cfg_monitor
#(
    parameter logic [6:0]  MAKER_CODE  = 7'h15,
    parameter logic [3:0]  MAKER_CONT  = 4'h1,
    parameter logic [15:0] PART_NUMBER = 16'h0A5C,
    parameter logic [3:0]  REVISION    = 4'h1
)
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire io_cfg_pkg::reg_req_s reg_req_i,
    input  wire logic [15:0]          reg_rdata_o,
    input  wire logic                 reg_rvalid_o,
    input  wire logic                 addr_filter_en_i,
    input  wire logic                 beacon_check_i,
    input  wire logic [15:0]          beacon_src_net_id_i,
    input  wire logic [15:0]          stored_net_id_i,
    input  wire logic                 beacon_accept_o,
    input  wire logic                 beacon_valid_o,
    input  wire logic                 rxbuf_level_i,
    input  wire logic [7:0]           rxbuf_count_i,
    input  wire logic [31:0]          frame_delim_sources_i,
    input  wire logic [31:0]          chan_clear_sources_i,
    input  wire logic                 rxbuf_level_pin_o,
    input  wire logic                 rxbuf_thresh_pin_o,
    input  wire logic                 frame_delim_pin_o,
    input  wire logic                 chan_clear_pin_o,
    input  wire logic                 freq_synth_on_i,
    input  wire logic                 fast_serial_debug_clk_o,
    input  wire logic                 fast_serial_debug_data_o,
    input  wire logic                 fast_serial_debug_take_o
);
    logic [11:0] cfg_a_q;
    logic [12:0] cfg_b_q;
    logic        dbg_idle;
    logic        delim_src;
    logic        clear_src;

    // ----------------
    // Shadow of the writable fields, fed by the same writes
    // ----------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            cfg_a_q <= 12'h040;
            cfg_b_q <= 13'h0000;
        end
        else
        begin
            if (reg_req_i.wr && reg_req_i.addr == io_cfg_pkg::OFS_IO_PIN_CONFIG_A)
                cfg_a_q <= reg_req_i.wdata[11:0];
            if (reg_req_i.wr && reg_req_i.addr == io_cfg_pkg::OFS_IO_PIN_CONFIG_B)
                cfg_b_q <= reg_req_i.wdata[12:0];
        end
    end

    // Reserved codes 4 and 5 count as off, like code 0
    assign dbg_idle  = !freq_synth_on_i || cfg_b_q[12:10] == 3'h0 || cfg_b_q[12:11] == 2'h2;
    assign delim_src = frame_delim_sources_i[cfg_b_q[9:5]];
    assign clear_src = chan_clear_sources_i[cfg_b_q[4:0]];

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    read_cfg_a_a: assert property (
        reg_req_i.rd && reg_req_i.addr == io_cfg_pkg::OFS_IO_PIN_CONFIG_A
        |=> reg_rvalid_o && reg_rdata_o == {4'h0, $past(cfg_a_q)}) else $error("config a readback wrong");
    read_cfg_b_a: assert property (
        reg_req_i.rd && reg_req_i.addr == io_cfg_pkg::OFS_IO_PIN_CONFIG_B
        |=> reg_rvalid_o && reg_rdata_o == {3'h0, $past(cfg_b_q)}) else $error("config b readback wrong");
    id_low_a: assert property (
        reg_req_i.rd && reg_req_i.addr == io_cfg_pkg::OFS_MAKER_ID_LOW
        |=> reg_rdata_o == {PART_NUMBER[3:0], MAKER_CONT, MAKER_CODE, 1'h1}) else $error("low identity wrong");
    id_high_a: assert property (
        reg_req_i.rd && reg_req_i.addr == io_cfg_pkg::OFS_MAKER_ID_HIGH
        |=> reg_rdata_o == {REVISION, PART_NUMBER[15:4]}) else $error("high identity wrong");
    beacon_verdict_a: assert property (beacon_check_i |=> beacon_valid_o && beacon_accept_o ==
        (!$past(addr_filter_en_i) || $past(cfg_a_q[11]) || $past(beacon_src_net_id_i) == $past(stored_net_id_i)))
        else $error("beacon verdict wrong");
    level_pin_a: assert property ($past(rst_n_i) |->
        rxbuf_level_pin_o == ($past(rxbuf_level_i) ^ $past(cfg_a_q[10]))) else $error("level pin wrong");
    thresh_pin_a: assert property ($past(rst_n_i) |-> rxbuf_thresh_pin_o ==
        (($past(rxbuf_count_i) >= {1'h0, $past(cfg_a_q[6:0])}) ^ $past(cfg_a_q[9]))) else $error("threshold pin wrong");
    delim_pin_a: assert property ($past(rst_n_i) |->
        frame_delim_pin_o == ($past(delim_src) ^ $past(cfg_a_q[8]))) else $error("delimiter pin wrong");
    clear_pin_a: assert property ($past(rst_n_i) |->
        chan_clear_pin_o == ($past(clear_src) ^ $past(cfg_a_q[7]))) else $error("clear pin wrong");
    debug_quiet_a: assert property (dbg_idle |-> ##2
        !fast_serial_debug_clk_o && !fast_serial_debug_data_o) else $error("debug output not quiet");
    debug_take_a: assert property (fast_serial_debug_take_o |-> !dbg_idle
        ##1 !fast_serial_debug_take_o [*4]) else $error("debug word taken wrongly");
endmodule

bind io_config_and_id_regs io_cfg_monitor #(
    .MAKER_CODE(MAKER_CODE), .MAKER_CONT(MAKER_CONT), .PART_NUMBER(PART_NUMBER), .REVISION(REVISION)
) i_mon (.*);

`default_nettype wire

/* dv/host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module host_model
(
    input  wire logic               clk_sys_i,
    output var io_cfg_pkg::reg_req_s reg_req_o,
    input  wire logic [15:0]        reg_rdata_i,
    input  wire logic               reg_rvalid_i
);
    initial reg_req_o = '0;

    task automatic write_reg(input logic [5:0] addr, input logic [15:0] data);
        if (addr == io_cfg_pkg::OFS_IO_PIN_CONFIG_A)
            data[15:12] = 4'h0;
        if (addr == io_cfg_pkg::OFS_IO_PIN_CONFIG_B)
            data[15:13] = 3'h0;
        @(negedge clk_sys_i);
        reg_req_o = '{1'h1, 1'h0, addr, data};
        @(negedge clk_sys_i);
        // Released lines show the inverse so stale values cannot pass
        reg_req_o = '{1'h0, 1'h0, ~addr, ~data};
    endtask

    task automatic read_reg(input logic [5:0] addr, output logic [15:0] data);
        @(negedge clk_sys_i);
        reg_req_o = '{1'h0, 1'h1, addr, ~reg_req_o.wdata};
        @(negedge clk_sys_i);
        data = reg_rvalid_i ? reg_rdata_i : 16'hXXXX;
        reg_req_o = '{1'h0, 1'h0, ~addr, reg_req_o.wdata};
    endtask
endmodule

`default_nettype wire

/* dv/test_io_config_and_id_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module test_io_config_and_id_regs;
    localparam logic [6:0]  CODE = 7'h2B;    // arbitrary value
    localparam logic [3:0]  CONT = 4'h5;     // arbitrary value
    localparam logic [15:0] PART = 16'hC3A9; // arbitrary value
    localparam logic [3:0]  REV  = 4'h6;     // arbitrary value

    logic clk_sys_i = 1'h0, rst_n_i = 1'h0, addr_filter_en_i = 1'h0, beacon_check_i = 1'h0;
    logic rxbuf_level_i = 1'h0, freq_synth_on_i = 1'h0, pre_tick_i = 1'h0, hold_tick = 1'h0;
    logic reg_rvalid_o, beacon_accept_o, beacon_valid_o, fast_serial_debug_clk_o;
    logic fast_serial_debug_data_o, fast_serial_debug_take_o;
    logic [7:0] rxbuf_count_i = 8'h00;
    logic [15:0] beacon_src_net_id_i = 16'h0000, stored_net_id_i = 16'h0000, reg_rdata_o, rd, mod_a, mod_b, w;
    logic [15:0] agc_status_i = 16'h0000, adc_iq_out_i = 16'h0000, filt_iq_i = 16'h0000;
    logic [15:0] adc_iq_in_i = 16'h0000, dac_iq_in_i = 16'h0000;
    logic [31:0] frame_delim_sources_i = 32'h0, chan_clear_sources_i = 32'h0, bg, r;
    logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    io_cfg_pkg::reg_req_s reg_req_i;
    integer seed = 74;
    int num_errors = 0, check_count = 0;

    io_config_and_id_regs #(.MAKER_CODE(CODE), .MAKER_CONT(CONT), .PART_NUMBER(PART), .REVISION(REV)) i_dut (
        .*, .rxbuf_level_pin_o(), .rxbuf_thresh_pin_o(), .frame_delim_pin_o(), .chan_clear_pin_o()
    );
    host_model i_host (.clk_sys_i, .reg_req_o(reg_req_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));

    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // Pin sources and prescaler ticks keep moving so the pin checks see real traffic
    always @(negedge clk_sys_i)
    begin
        bg = $random(seed);
        rxbuf_level_i <= bg[0];
        rxbuf_count_i <= bg[8:1];
        pre_tick_i <= hold_tick | bg[9];
        freq_synth_on_i <= hold_tick | bg[10];
        frame_delim_sources_i <= $random(seed);
        chan_clear_sources_i <= $random(seed);
    end

    function automatic logic [15:0] expect_rd(input logic [5:0] a);
        case (a)
            io_cfg_pkg::OFS_IO_PIN_CONFIG_A: return mod_a;
            io_cfg_pkg::OFS_IO_PIN_CONFIG_B: return mod_b;
            io_cfg_pkg::OFS_MAKER_ID_LOW:    return {PART[3:0], CONT, CODE, 1'h1};
            io_cfg_pkg::OFS_MAKER_ID_HIGH:   return {REV, PART[15:4]};
            default:                         return 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] dbg_word(input logic [2:0] c);
        case (c)
            3'h1:    return agc_status_i;
            3'h2:    return adc_iq_out_i;
            3'h3:    return filt_iq_i;
            3'h6:    return adc_iq_in_i;
            default: return dac_iq_in_i;
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("Errors %0d, checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #(40 * 20000);
        num_errors++;
        give_verdict();
    end

    initial
    begin
        mod_a = 16'h0040;
        mod_b = 16'h0000;
        repeat (20) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'h1;
        // ----------
        // Reset values, identity, unmapped and read-only places
        // ----------
        repeat (2)
        begin
            for (int i = 0; i < 8; i++)
            begin
                i_host.read_reg(6'h1A + 6'(i), rd);
                check(rd, expect_rd(6'h1A + 6'(i)));
                if (i != 2 && i != 3)
                    i_host.write_reg(6'h1A + 6'(i), 16'hFFFF);
            end
        end
        // ----------
        // Random configuration with beacon checks in every mode
        // ----------
        for (int k = 0; k < 40; k++)
        begin
            r = $random(seed);
            mod_a = {4'h0, r[11:0]};
            mod_b = {3'h0, r[28:16]};
            if (k == 0)
                mod_a[6:0] = 7'h00;
            if (k == 1)
                mod_a[6:0] = 7'h7F;
            i_host.write_reg(io_cfg_pkg::OFS_IO_PIN_CONFIG_A, mod_a);
            i_host.write_reg(io_cfg_pkg::OFS_IO_PIN_CONFIG_B, mod_b);
            i_host.read_reg(io_cfg_pkg::OFS_IO_PIN_CONFIG_A, rd);
            check(rd, mod_a);
            i_host.read_reg(io_cfg_pkg::OFS_IO_PIN_CONFIG_B, rd);
            check(rd, mod_b);
            @(negedge clk_sys_i);
            addr_filter_en_i = k[0];
            stored_net_id_i = mod_a[11] ? 16'hFFFF : $random(seed);
            beacon_src_net_id_i = k[1] ? stored_net_id_i : ~stored_net_id_i;
            beacon_check_i = 1'h1;
            @(negedge clk_sys_i);
            beacon_check_i = 1'h0;
            check({14'h0000, beacon_valid_o, beacon_accept_o}, {14'h0000, 1'h1, !k[0] || mod_a[11] || k[1]});
        end
        // ----------
        // Serial debug stream for every valid source code
        // ----------
        hold_tick = 1'h1;
        {agc_status_i, adc_iq_out_i, filt_iq_i} = {$random(seed), $random(seed)};
        {adc_iq_in_i, dac_iq_in_i} = $random(seed);
        foreach (codes[c])
        begin
            i_host.write_reg(io_cfg_pkg::OFS_IO_PIN_CONFIG_B, 16'h0000);
            i_host.write_reg(io_cfg_pkg::OFS_IO_PIN_CONFIG_B, {3'h0, codes[c], 10'h000});
            for (int n = 0; n < 20 && fast_serial_debug_take_o !== 1'h1; n++)
                @(negedge clk_sys_i);
            repeat (16)
            begin
                @(posedge fast_serial_debug_clk_o);
                @(negedge clk_sys_i);
                w = {w[14:0], fast_serial_debug_data_o};
            end
            check(w, dbg_word(codes[c]));
        end
        hold_tick = 1'h0;
        repeat (10) @(negedge clk_sys_i);
        give_verdict();
    end
endmodule

`default_nettype wire
